// File: rtl/sfl_defines.vh
// constants for the supply fault detector control logic
`ifndef SFL_DEFINES_VH
`define SFL_DEFINES_VH

// clock rate
`define SFL_CLK_HZ 10000000

// detector count and register map
`define SFL_DET_COUNT  7
`define SFL_BASE_ADDR  8'ha0
`define SFL_LAST_ADDR  8'hd4
`define SFL_OFF_OVTH   3'h0
`define SFL_OFF_OVHYST 3'h1
`define SFL_OFF_UVTH   3'h2
`define SFL_OFF_UVHYST 3'h3
`define SFL_OFF_SEL    3'h4

// detector slots
`define SFL_BIPOLAR_LAST 3'h1
`define SFL_HIGH_SLOT    3'h2

// reset values
`define SFL_OVTH_RST 8'hff
`define SFL_UVTH_RST 8'h00
`define SFL_HYST_RST 5'h00
`define SFL_SEL_RST  8'h00

// field positions
`define SFL_HYST_W    5
`define SFL_POL_BIT   7
`define SFL_GF_HI     6
`define SFL_GF_LO     4
`define SFL_RANGE_HI  3
`define SFL_RANGE_LO  2
`define SFL_TYPE_HI   1
`define SFL_TYPE_LO   0

// fault type codes
`define SFL_TYPE_UV  2'h0
`define SFL_TYPE_OV  2'h1
`define SFL_TYPE_WIN 2'h2

// range codes
`define SFL_RANGE_MID   2'h0
`define SFL_RANGE_LOW   2'h1
`define SFL_RANGE_ULOW  2'h2
`define SFL_RANGE_HIGH  2'h3
`define SFL_RANGE_NEG   2'h3

// glitch filter delays in microseconds
`define SFL_GF0_US 0
`define SFL_GF1_US 5
`define SFL_GF2_US 10
`define SFL_GF3_US 20
`define SFL_GF4_US 40
`define SFL_GF5_US 60
`define SFL_GF6_US 80
`define SFL_GF7_US 100
`define SFL_GF_CW  10
`define SFL_US_CYC(t) (((t) * (`SFL_CLK_HZ / 1000000)))

`endif

// File: rtl/sfl_glitch_filter.v
// glitch filter for one detector fault output
`timescale 1ns/1ns
`include "sfl_defines.vh"

module sfl_glitch_filter #(
   parameter CW = `SFL_GF_CW
) (
   input  wire          clk,
   input  wire          rstN,
   input  wire          faultIn,
   input  wire [CW-1:0] delayCycles,
   output reg           faultOut
);

   reg [CW-1:0] count;
   reg          prevIn;

   // counter restarts on every input change; output follows after the
   // input has held its new level for the whole delay
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         count    <= {CW{1'b0}};
         prevIn   <= 1'b0;
         faultOut <= 1'b0;
      end else begin
         prevIn <= faultIn;
         if (faultIn != prevIn || faultIn == faultOut) begin
            count <= {CW{1'b0}};
         end else begin
            count <= count + {{(CW-1){1'b0}}, 1'b1};
         end
         // short pulses never reach the end of the count
         if (faultIn == prevIn && faultIn != faultOut &&
             count + {{(CW-1){1'b0}}, 1'b1} >= delayCycles) begin
            faultOut <= faultIn;
         end
      end
   end

endmodule // sfl_glitch_filter

// File: rtl/sfl_detector_top.v
// seven supply fault detectors: registers, hysteresis, fault select
`timescale 1ns/1ns
`include "sfl_defines.vh"

// Function
// - seven detectors: high, two bipolar, four positive
// - one fault type active per detector
// - undervoltage fault when comparator output high
// - undervoltage threshold is 8-bit code
// - overvoltage fault uses own comparator, code
// - one 8-bit register per threshold
// - threshold voltage set by code over 255
// - selectable ranges per detector kind
// - range bottom is one third of top
// - hysteresis registers separate from thresholds
// - only five hysteresis bits are settable
// - hysteresis applies only once fault asserted
// - hysteresis step equals threshold step
// - bipolar polarity bit at bit 7
// - negative mode allows only -6 to -2 V
// - window fault ORs undervoltage and overvoltage
// - fault type in bits 1 and 0
// - glitch filter last, timeout up to 100 us
// - short pulses suppressed, long pulses passed
// - filtered output lags by programmed timeout
// - glitch delay code in select bits 6-4
// - overvoltage thresholds reset ones, others zero
module sfl_detector_top #(
   parameter NDET = `SFL_DET_COUNT
) (
   input  wire            clk,
   input  wire            nrst,
   // register port
   input  wire [7:0]      regAddr,
   input  wire [7:0]      regWrData,
   input  wire            regWrEn,
   input  wire            regRdEn,
   output reg  [7:0]      regRdData,
   // comparator pins
   input  wire [NDET-1:0] uvCompIn,
   input  wire [NDET-1:0] ovCompIn,
   // analog controls and filtered faults
   output reg  [8*NDET-1:0] uvDacCode,
   output reg  [8*NDET-1:0] ovDacCode,
   output reg  [2*NDET-1:0] rangeSel,
   output reg  [NDET-1:0] negMode,
   output wire [NDET-1:0] faultOut
);

   // reset release pipeline
   reg [1:0] rstPipe;
   wire      rstN;

   // register storage, indexed by detector slot
   reg [7:0] ovTh   [0:NDET-1];
   reg [4:0] ovHyst [0:NDET-1];
   reg [7:0] uvTh   [0:NDET-1];
   reg [4:0] uvHyst [0:NDET-1];
   reg [7:0] selReg [0:NDET-1];

   // comparator synchronisers and settled levels
   reg [NDET-1:0] uvS1;
   reg [NDET-1:0] uvS2;
   reg [NDET-1:0] uvS3;
   reg [NDET-1:0] ovS1;
   reg [NDET-1:0] ovS2;
   reg [NDET-1:0] ovS3;
   reg [NDET-1:0] uvLevel;
   reg [NDET-1:0] ovLevel;

   // unfiltered fault per detector
   reg [NDET-1:0] rawFault;

   // read data for the next edge
   reg [7:0]      next_regRdData;

   wire       addrHit;
   wire [2:0] addrSlot;
   wire [2:0] addrOff;
   wire [7:0] addrDiff;

   // the async reset is released through two flops so every register
   // leaves reset on the same clean edge
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstPipe <= 2'b00;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstN = rstPipe[1];

   // address decode: each detector owns an 8-byte group
   assign addrDiff = regAddr - `SFL_BASE_ADDR;
   assign addrSlot = addrDiff[5:3];
   assign addrOff  = addrDiff[2:0];
   assign addrHit  = (regAddr >= `SFL_BASE_ADDR) &&
                     (regAddr <= `SFL_LAST_ADDR) &&
                     (addrOff <= `SFL_OFF_SEL);

   // true for the two detectors that can watch negative supplies
   function isBipolar;
      input [2:0] slot;
      begin
         isBipolar = (slot <= `SFL_BIPOLAR_LAST);
      end
   endfunction

   // glitch delay code to cycle count at the system clock
   function [`SFL_GF_CW-1:0] gfCycles;
      input [2:0]  code;
      reg   [31:0] cyc;
      begin
         case (code)
            3'h0:    cyc = `SFL_US_CYC(`SFL_GF0_US);
            3'h1:    cyc = `SFL_US_CYC(`SFL_GF1_US);
            3'h2:    cyc = `SFL_US_CYC(`SFL_GF2_US);
            3'h3:    cyc = `SFL_US_CYC(`SFL_GF3_US);
            3'h4:    cyc = `SFL_US_CYC(`SFL_GF4_US);
            3'h5:    cyc = `SFL_US_CYC(`SFL_GF5_US);
            3'h6:    cyc = `SFL_US_CYC(`SFL_GF6_US);
            default: cyc = `SFL_US_CYC(`SFL_GF7_US);
         endcase
         // longest delay fits the filter counter, so the upper bits are zero
         gfCycles = cyc[`SFL_GF_CW-1:0];
      end
   endfunction

   // coerce the range field to one the detector kind supports; the
   // analog divider has no setting for the others
   function [1:0] legalRange;
      input [2:0] slot;
      input       neg;
      input [1:0] code;
      begin
         if (isBipolar(slot) && neg) begin
            legalRange = `SFL_RANGE_NEG;
         end else if (isBipolar(slot)) begin
            if (code == `SFL_RANGE_LOW) begin
               legalRange = `SFL_RANGE_LOW;
            end else begin
               legalRange = `SFL_RANGE_MID;
            end
         end else if (slot == `SFL_HIGH_SLOT) begin
            if (code == `SFL_RANGE_HIGH) begin
               legalRange = `SFL_RANGE_HIGH;
            end else begin
               legalRange = `SFL_RANGE_MID;
            end
         end else begin
            if (code == `SFL_RANGE_HIGH) begin
               legalRange = `SFL_RANGE_MID;
            end else begin
               legalRange = code;
            end
         end
      end
   endfunction

   // threshold plus hysteresis, held at full scale
   function [7:0] addSat;
      input [7:0] th;
      input [4:0] hy;
      reg   [8:0] sum;
      begin
         sum = {1'b0, th} + {4'h0, hy};
         addSat = sum[8] ? 8'hff : sum[7:0];
      end
   endfunction

   // threshold minus hysteresis, held at zero
   function [7:0] subSat;
      input [7:0] th;
      input [4:0] hy;
      begin
         subSat = (th < {3'h0, hy}) ? 8'h00 : th - {3'h0, hy};
      end
   endfunction

   // a synchronised level changes only when the second and third flops
   // agree; otherwise the last accepted level holds
   function [NDET-1:0] settle;
      input [NDET-1:0] s2;
      input [NDET-1:0] s3;
      input [NDET-1:0] held;
      begin
         settle = (s2 & s3) | (held & (s2 | s3));
      end
   endfunction

   // read mux; reserved bits and unmapped addresses read zero
   always @* begin
      next_regRdData = regRdData;
      if (regRdEn) begin
         if (!addrHit) begin
            next_regRdData = 8'h00;
         end else begin
            case (addrOff)
               `SFL_OFF_OVTH:   next_regRdData = ovTh[addrSlot];
               `SFL_OFF_OVHYST: next_regRdData = {3'h0, ovHyst[addrSlot]};
               `SFL_OFF_UVTH:   next_regRdData = uvTh[addrSlot];
               `SFL_OFF_UVHYST: next_regRdData = {3'h0, uvHyst[addrSlot]};
               `SFL_OFF_SEL:    next_regRdData = selReg[addrSlot];
               default:         next_regRdData = 8'h00;
            endcase
         end
      end
   end

   // read data holds until the next read strobe
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= next_regRdData;
      end
   end

   // undervoltage comparator capture; three flops so that a metastable
   // first sample never counts as a level change
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         uvS1    <= {NDET{1'b0}};
         uvS2    <= {NDET{1'b0}};
         uvS3    <= {NDET{1'b0}};
         uvLevel <= {NDET{1'b0}};
      end else begin
         uvS1    <= uvCompIn;
         uvS2    <= uvS1;
         uvS3    <= uvS2;
         uvLevel <= settle(uvS2, uvS3, uvLevel);
      end
   end

   // overvoltage comparator capture, same scheme
   always @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ovS1    <= {NDET{1'b0}};
         ovS2    <= {NDET{1'b0}};
         ovS3    <= {NDET{1'b0}};
         ovLevel <= {NDET{1'b0}};
      end else begin
         ovS1    <= ovCompIn;
         ovS2    <= ovS1;
         ovS3    <= ovS2;
         ovLevel <= settle(ovS2, ovS3, ovLevel);
      end
   end

   // per-detector logic: slots 0 and 1 bipolar, 2 high voltage, 3 to 6 positive
   genvar i;
   generate
      for (i = 0; i < NDET; i = i + 1) begin : gDet
         // slot number, cut to the width of the address decode
         localparam [31:0] SLOT = i;
         wire       hit;
         wire [1:0] ftype;
         wire       polWr;

         assign hit   = regWrEn && addrHit && (addrSlot == SLOT[2:0]);
         assign ftype = selReg[i][`SFL_TYPE_HI:`SFL_TYPE_LO];
         // polarity exists only on the bipolar detectors
         assign polWr = isBipolar(SLOT[2:0]) ? regWrData[`SFL_POL_BIT] : 1'b0;

         // host writes; one register per threshold and per hysteresis
         always @(posedge clk or negedge rstN) begin
            if (!rstN) begin
               ovTh[i]   <= `SFL_OVTH_RST;
               ovHyst[i] <= `SFL_HYST_RST;
               uvTh[i]   <= `SFL_UVTH_RST;
               uvHyst[i] <= `SFL_HYST_RST;
               selReg[i] <= `SFL_SEL_RST;
            end else if (hit) begin
               case (addrOff)
                  `SFL_OFF_OVTH:   ovTh[i]   <= regWrData;
                  `SFL_OFF_OVHYST: ovHyst[i] <= regWrData[`SFL_HYST_W-1:0];
                  `SFL_OFF_UVTH:   uvTh[i]   <= regWrData;
                  `SFL_OFF_UVHYST: uvHyst[i] <= regWrData[`SFL_HYST_W-1:0];
                  `SFL_OFF_SEL:    selReg[i] <= {polWr, regWrData[6:0]};
                  default:         selReg[i] <= selReg[i];
               endcase
            end
         end

         // dac codes shift by the hysteresis only while the fault is up,
         // so the comparator must cross back past the widened level
         always @(posedge clk or negedge rstN) begin
            if (!rstN) begin
               uvDacCode[8*i+7:8*i] <= `SFL_UVTH_RST;
               ovDacCode[8*i+7:8*i] <= `SFL_OVTH_RST;
            end else begin
               uvDacCode[8*i+7:8*i] <= uvLevel[i] ?
                  addSat(uvTh[i], uvHyst[i]) : uvTh[i];
               ovDacCode[8*i+7:8*i] <= ovLevel[i] ?
                  subSat(ovTh[i], ovHyst[i]) : ovTh[i];
            end
         end

         // range and polarity steer the analog divider
         always @(posedge clk or negedge rstN) begin
            if (!rstN) begin
               rangeSel[2*i+1:2*i] <= `SFL_RANGE_MID;
               negMode[i]          <= 1'b0;
            end else begin
               rangeSel[2*i+1:2*i] <= legalRange(SLOT[2:0],
                  selReg[i][`SFL_POL_BIT],
                  selReg[i][`SFL_RANGE_HI:`SFL_RANGE_LO]);
               negMode[i]          <= selReg[i][`SFL_POL_BIT];
            end
         end

         // one fault type at a time; the spare code acts as window
         always @(posedge clk or negedge rstN) begin
            if (!rstN) begin
               rawFault[i] <= 1'b0;
            end else begin
               case (ftype)
                  `SFL_TYPE_UV: rawFault[i] <= uvLevel[i];
                  `SFL_TYPE_OV: rawFault[i] <= ovLevel[i];
                  default:      rawFault[i] <= uvLevel[i] | ovLevel[i];
               endcase
            end
         end

         // final stage: timeout taken from the select register
         sfl_glitch_filter #(
            .CW (`SFL_GF_CW)
         ) uFilter (
            .clk         (clk),
            .rstN        (rstN),
            .faultIn     (rawFault[i]),
            .delayCycles (gfCycles(selReg[i][`SFL_GF_HI:`SFL_GF_LO])),
            .faultOut    (faultOut[i])
         );
      end
   endgenerate

endmodule // sfl_detector_top

// File: testbench/sfl_detector_monitor.sv
// assertion checker for the supply fault detector top
`timescale 1ns/1ns
module sfl_detector_monitor #(
   parameter NDET = 7
) (
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic [7:0]        regAddr,
   input wire logic [7:0]        regWrData,
   input wire logic              regWrEn,
   input wire logic              regRdEn,
   input wire logic [7:0]        regRdData,
   input wire logic [NDET-1:0]   uvCompIn,
   input wire logic [NDET-1:0]   ovCompIn,
   input wire logic [8*NDET-1:0] uvDacCode,
   input wire logic [8*NDET-1:0] ovDacCode,
   input wire logic [2*NDET-1:0] rangeSel,
   input wire logic [NDET-1:0]   negMode,
   input wire logic [NDET-1:0]   faultOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // decode helpers; offsets 5..7 of each slot are holes
   wire mapped   = regAddr >= 8'ha0 && regAddr <= 8'hd4 && regAddr[2:0] <= 3'h4;
   wire isThr    = mapped && (regAddr[2:0] == 3'h0 || regAddr[2:0] == 3'h2);
   wire isHyst   = mapped && regAddr[0];
   wire isPosSel = mapped && regAddr[2:0] == 3'h4 && regAddr >= 8'hb0;
   // a threshold write followed by a read of the same byte
   sequence wrThr;
      regWrEn && isThr;
   endsequence
   sequence rdSame;
      !regWrEn ##1 regRdEn && regAddr == $past(regAddr, 2);
   endsequence
   a_thr_readback: assert property (wrThr ##1 rdSame |=> regRdData == $past(regWrData, 3))
      else $error("threshold readback differs from written byte");
   a_hole_reads_zero: assert property (regRdEn && !mapped |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   a_hyst_top_zero: assert property (regRdEn && isHyst |=> regRdData[7:5] == 3'h0)
      else $error("hysteresis upper bits not zero");
   a_pol_pos_zero: assert property (regRdEn && isPosSel |=> !regRdData[7])
      else $error("polarity bit on non-bipolar slot");
   a_rd_data_holds: assert property (!regRdEn |=> $stable(regRdData))
      else $error("read data changed without a read");
   a_pos_no_neg: assert property (negMode[NDET-1:2] == '0)
      else $error("negative mode on non-bipolar slot");
   a_neg_range_only: assert property ((negMode[0] -> rangeSel[1:0] == 2'h3) &&
      (negMode[1] -> rangeSel[3:2] == 2'h3)) else $error("negative mode with wrong range");
   a_pol_sets_neg: assert property (regWrEn && regAddr == 8'ha4 |->
      ##2 {negMode[0], 7'h00} == ($past(regWrData, 2) & 8'h80))
      else $error("polarity write not reflected");
endmodule // sfl_detector_monitor

bind sfl_detector_top sfl_detector_monitor #(.NDET(NDET)) sfl_detector_monitor_i (
   .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
   .regRdEn(regRdEn), .regRdData(regRdData), .uvCompIn(uvCompIn), .ovCompIn(ovCompIn),
   .uvDacCode(uvDacCode), .ovDacCode(ovDacCode), .rangeSel(rangeSel), .negMode(negMode),
   .faultOut(faultOut));

// File: testbench/sfl_supply_model.sv
// comparator pairs facing the detector dac codes
`timescale 1ns/1ns
module sfl_supply_model #(
   parameter NDET = 7
) (
   input  wire logic [8*NDET-1:0] supplyLevel,
   input  wire logic              clk,
   input  wire logic [8*NDET-1:0] uvDacCode,
   input  wire logic [8*NDET-1:0] ovDacCode,
   output logic      [NDET-1:0]   uvCompIn,
   output logic      [NDET-1:0]   ovCompIn
);
   // each detector sees only its own input; one comparator settling cycle
   always @(posedge clk) begin
      for (int k = 0; k < NDET; k++) begin
         uvCompIn[k] <= supplyLevel[8*k+:8] < uvDacCode[8*k+:8];
         ovCompIn[k] <= supplyLevel[8*k+:8] > ovDacCode[8*k+:8];
      end
   end
endmodule // sfl_supply_model

// File: testbench/tb_sfl_detector_top.sv
// self-checking bench for the supply fault detector top
`timescale 1ns/1ns
module tb_sfl_detector_top;
   localparam N = 7;
   logic           clk = 1'b0;
   logic           nrst = 1'b0;
   logic [7:0]     regAddr = 8'h00;
   logic [7:0]     regWrData = 8'h00;
   logic           regWrEn = 1'b0;
   logic           regRdEn = 1'b0;
   logic [8*N-1:0] supplyLevel = {N{8'h80}};
   wire  [7:0]     regRdData;
   wire  [N-1:0]   uvCompIn, ovCompIn, negMode, faultOut;
   wire  [8*N-1:0] uvDacCode, ovDacCode;
   wire  [2*N-1:0] rangeSel;
   int             n_errors = 0;
   int             tests_run = 0;
   logic [7:0]     rdv;
   int             lag;
   // 10 MHz
   always #50 clk = ~clk;
   sfl_detector_top #(.NDET(N)) sfl_detector_top_i (.clk(clk), .nrst(nrst),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .uvCompIn(uvCompIn), .ovCompIn(ovCompIn),
      .uvDacCode(uvDacCode), .ovDacCode(ovDacCode), .rangeSel(rangeSel),
      .negMode(negMode), .faultOut(faultOut));
   sfl_supply_model #(.NDET(N)) sfl_supply_model_i (.clk(clk), .supplyLevel(supplyLevel),
      .uvDacCode(uvDacCode), .ovDacCode(ovDacCode), .uvCompIn(uvCompIn),
      .ovCompIn(ovCompIn));
   task automatic results();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one write strobe, then an idle edge so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      @(posedge clk);
      #1 d = regRdData;
   endtask
   task automatic setLevel(input int k, input logic [7:0] v);
      @(posedge clk);
      supplyLevel[8*k+:8] <= v;
   endtask
   // bounded wait; a hang ends the run
   task automatic waitFault(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (faultOut[k] !== v && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
      if (faultOut[k] !== v) begin
         n_errors++;
         results();
      end
   endtask
   function automatic logic [7:0] dacOf(input int k, input logic ov);
      return ov ? ovDacCode[8*k+:8] : uvDacCode[8*k+:8];
   endfunction
   // defaults, all-ones readback of every slot, then holes
   task automatic regMap();
      logic [7:0] a;
      logic [7:0] e;
      for (int s = 0; s < N; s++) begin
         for (int o = 0; o < 5; o++) begin
            a = 8'ha0 + 8'(8 * s + o);
            rd(a, rdv);
            check("default", rdv, (o == 0) ? 8'hff : 8'h00);
            wr(a, 8'hff);
            rd(a, rdv);
            e = (o == 1 || o == 3) ? 8'h1f : (o == 4 && s > 1) ? 8'h7f : 8'hff;
            check("readback", rdv, e);
            wr(a, (o == 0) ? 8'hff : 8'h00);
         end
      end
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 8'h9f : (i == 1) ? 8'ha5 : (i == 2) ? 8'hb7 : 8'hd5;
         wr(a, 8'h5a);
         rd(a, rdv);
         check("hole", rdv, 8'h00);
      end
   endtask
   // polarity forces the negative range; an illegal range reads back but drives zero
   task automatic ranges();
      wr(8'ha4, 8'h80);
      wr(8'hb4, 8'h0c);
      wr(8'hbc, 8'h0c);
      wr(8'hac, 8'h84);
      tick(3);
      check("neg", {6'h00, negMode[1:0]}, 8'h03);
      check("range", rangeSel[7:0], 8'h3f);
      rd(8'hbc, rdv);
      check("stored", rdv, 8'h0c);
      wr(8'ha4, 8'h04);
      wr(8'hac, 8'h08);
      wr(8'hb4, 8'h04);
      wr(8'hbc, 8'h08);
      tick(3);
      check("pos", {6'h00, negMode[1:0]}, 8'h00);
      check("range", rangeSel[7:0], 8'h81);
   endtask
   // hysteresis shifts the dac code only while the fault stands
   task automatic hyst(input int k, input logic ov, input logic [7:0] th, hy, ok, bad, mid);
      logic [7:0] a;
      logic [7:0] held;
      a = 8'ha0 + 8'(8 * k);
      held = ov ? th - hy : th + hy;
      wr(ov ? a : a + 8'h02, th);
      wr(ov ? a + 8'h01 : a + 8'h03, hy);
      wr(a + 8'h04, {7'h00, ov});
      setLevel(k, ok);
      tick(20);
      check("dac", dacOf(k, ov), th);
      check("quiet", {7'h00, faultOut[k]}, 8'h00);
      setLevel(k, bad);
      waitFault(k, 1'b1, 40, lag);
      check("dacheld", dacOf(k, ov), held);
      setLevel(k, mid);
      tick(20);
      check("hold", {7'h00, faultOut[k]}, 8'h01);
      setLevel(k, ok);
      waitFault(k, 1'b0, 40, lag);
   endtask
   // every fault type code against a low and a high excursion
   task automatic types();
      logic [3:0] lowHit;
      logic [3:0] highHit;
      lowHit = 4'b1101;
      highHit = 4'b1110;
      wr(8'hc1, 8'h00);
      wr(8'hc2, 8'h40);
      for (int t = 0; t < 4; t++) begin
         wr(8'hc4, 8'(t));
         setLevel(4, 8'h20);
         tick(20);
         check("low", {7'h00, faultOut[4]}, {7'h00, lowHit[t]});
         setLevel(4, 8'he0);
         tick(20);
         check("high", {7'h00, faultOut[4]}, {7'h00, highHit[t]});
         setLevel(4, 8'h80);
         tick(20);
      end
   endtask
   // short pulse masked, long pulse delayed by the timeout (5 us and 100 us)
   task automatic glitch();
      int seen;
      seen = 0;
      wr(8'hca, 8'h80);
      wr(8'hcc, 8'h10);
      setLevel(5, 8'h60);
      tick(30);
      setLevel(5, 8'ha0);
      for (int i = 0; i < 100; i++) begin
         @(posedge clk);
         #1 if (faultOut[5] !== 1'b0) seen++;
      end
      check("short", 8'(seen), 8'h00);
      setLevel(5, 8'h60);
      waitFault(5, 1'b1, 200, lag);
      check("lag5", {7'h00, lag >= 50 && lag <= 60}, 8'h01);
      setLevel(5, 8'ha0);
      waitFault(5, 1'b0, 200, lag);
      wr(8'hcc, 8'h70);
      setLevel(5, 8'h60);
      waitFault(5, 1'b1, 1200, lag);
      check("lag100", {7'h00, lag >= 1000 && lag <= 1010}, 8'h01);
   endtask
   initial begin
      tick(16);
      nrst <= 1'b1;
      tick(3);
      check("ovdac", ovDacCode[7:0], 8'hff);
      check("uvdac", uvDacCode[7:0], 8'h00);
      regMap();
      ranges();
      hyst(3, 1'b0, 8'h80, 8'h10, 8'h90, 8'h70, 8'h88);
      hyst(4, 1'b1, 8'hc0, 8'h08, 8'hb0, 8'hd0, 8'hbc);
      types();
      glitch();
      results();
   end
endmodule // tb_sfl_detector_top
